// ==== testbench.sv ====
// Self-checking bench for transmit queue, enables and interrupt identity
`timescale 1ns/1ns
module testbench;
  import uart_pkg::*;
  localparam logic [7:0] A_TXQ = {IDX_TXQ, 2'b00};
  localparam logic [7:0] A_ENA = {IDX_ENA, 2'b00};
  localparam logic [7:0] A_IDN = {IDX_IDN, 2'b00};
  localparam logic [7:0] A_LCR = {IDX_LCR, 2'b00};
  localparam int unsigned EN_OF [7] = '{EN_RDA, EN_RDA, EN_ERR, EN_MDM, EN_FLOW, EN_RTS, EN_CTS};
  localparam logic [7:0] CODE_OF [7] = '{CODE_RDA, CODE_TMO, CODE_ERR, CODE_MDM, CODE_FLOW, CODE_LINE, CODE_LINE};

  logic        i_clock;
  logic        i_sys_rst;
  logic [7:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [6:0]  src;
  logic [7:0]  o_tx_data;
  logic        o_tx_valid;
  logic        i_tx_ready;
  logic        o_irq;
  logic        stall;
  logic [4:0]  sink_count;
  logic [31:0] rd;
  int          bad_count;
  int          checks;

  uart_tx_holding_irq #(.FIFO_DEPTH(TXQ_DEPTH)) i_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_rx_data_ready(src[0]), .i_rx_timeout(src[1]),
    .i_rx_error(src[2]), .i_modem_change(src[3]), .i_flow_char(src[4]),
    .i_rts_dtr_change(src[5]), .i_cts_dsr_change(src[6]), .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_irq(o_irq));

  tx_sink i_sink (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_stall(stall), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_count(sink_count));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_byteenable <= be;
    i_avs_write <= w;
    i_avs_read <= !w;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (o_avs_waitrequest !== 1'b0) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00, 4'hf);
    chk_reg(rd, {24'h000000, exp});
  endtask

  task automatic fire(input int k);
    @(posedge i_clock);
    src[k] <= 1'b1;
    if (k > 1) begin
      @(posedge i_clock);
      src[k] <= 1'b0;
    end
    repeat (3) @(posedge i_clock);
  endtask

  task automatic quiet(input int k);
    @(posedge i_clock);
    src[k] <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask

  task automatic wait_sink(input logic [4:0] n);
    int t;
    for (t = 0; t < 60 && sink_count !== n; t++) @(posedge i_clock);
    if (sink_count !== n) begin
      bad_count++;
      complete_run();
    end
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_avs_address = 8'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h00000000;
    i_avs_byteenable = 4'h0;
    src = 7'h00;
    stall = 1'b1;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    // ------------------------------------------------------------
    // Reset values and access kinds
    // ------------------------------------------------------------
    rd_chk(A_IDN, CODE_NONE);
    rd_chk(A_ENA, ENA_RESET);
    chk_bit(o_irq, 1'b0);
    wr(A_ENA, 8'h7f);
    rd_chk(A_ENA, 8'h7f);
    bus(A_ENA, 1'b1, 8'h00, 4'h0);
    rd_chk(A_ENA, 8'h7f);
    wr(A_ENA, 8'h00);
    wr(A_IDN, 8'h00);
    rd_chk(A_IDN, CODE_NONE);
    rd_chk(8'h3c, 8'h00);
    rd_chk(A_TXQ, 8'h00);
    $display("test registers done");
    // ------------------------------------------------------------
    // Fill queue past full with transmitter stalled, then drain
    // ------------------------------------------------------------
    for (int k = 0; k <= TXQ_DEPTH; k++) wr(A_TXQ, 8'h10 + 8'(k));
    rd_chk(A_LCR, 8'h40);
    @(posedge i_clock);
    stall <= 1'b0;
    wait_sink(5'(TXQ_DEPTH));
    repeat (5) @(posedge i_clock);
    chk_reg({27'h0, sink_count}, 32'(TXQ_DEPTH));
    for (int k = 0; k < TXQ_DEPTH; k++) chk_reg({24'h0, i_sink.got_q[k]}, 32'h10 + 32'(k));
    rd_chk(A_LCR, 8'h20);
    $display("test queue done");
    // ------------------------------------------------------------
    // Transmit empty source
    // ------------------------------------------------------------
    wr(A_ENA, 8'h02);
    rd_chk(A_IDN, CODE_TXE);
    rd_chk(A_IDN, CODE_NONE);
    wr(A_TXQ, 8'h55);
    wait_sink(5'(TXQ_DEPTH + 1));
    repeat (4) @(posedge i_clock);
    chk_bit(o_irq, 1'b1);
    rd_chk(A_IDN, CODE_TXE);
    wr(A_ENA, 8'h00);
    $display("test tx empty done");
    // ------------------------------------------------------------
    // Each source except transmit empty enabled alone, then gated off
    // ------------------------------------------------------------
    for (int k = 0; k < 7; k++) begin
      wr(A_ENA, 8'h01 << EN_OF[k]);
      fire(k);
      chk_bit(o_irq, 1'b1);
      rd_chk(A_IDN, CODE_OF[k]);
      if (k < 2) quiet(k);
      rd_chk(A_IDN, CODE_NONE);
      repeat (2) @(posedge i_clock);
      chk_bit(o_irq, 1'b0);
      wr(A_ENA, 8'h00);
      fire(k);
      chk_bit(o_irq, 1'b0);
      rd_chk(A_IDN, CODE_NONE);
      if (k < 2) quiet(k);
    end
    $display("test sources done");
    // ------------------------------------------------------------
    // All sources pending, served in priority order
    // ------------------------------------------------------------
    wr(A_ENA, 8'h7f);
    for (int k = 0; k < 7; k++) fire(k);
    rd_chk(A_IDN, CODE_ERR);
    rd_chk(A_IDN, CODE_RDA);
    quiet(0);
    rd_chk(A_IDN, CODE_TMO);
    quiet(1);
    rd_chk(A_IDN, CODE_TXE);
    rd_chk(A_IDN, CODE_MDM);
    rd_chk(A_IDN, CODE_FLOW);
    rd_chk(A_IDN, CODE_LINE);
    rd_chk(A_IDN, CODE_NONE);
    repeat (2) @(posedge i_clock);
    chk_bit(o_irq, 1'b0);
    $display("test priority done");
    complete_run();
  end

  initial begin
    #900000;
    bad_count++;
    complete_run();
  end
endmodule

// ==== tx_sink.sv ====
// Transmitter stand-in that drains the transmit queue and records each byte
`timescale 1ns/1ns
module tx_sink (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // Stall control
  input  wire logic       i_stall,
  // Queue drain side
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  // Captured byte count
  output logic [4:0]      o_count
);
  logic [7:0] got_q [16];

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= !i_stall;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_count <= 5'h00;
    end else if (i_tx_valid && o_tx_ready) begin
      got_q[o_count[3:0]] <= i_tx_data;
      o_count <= o_count + 5'h01;
    end
  end
endmodule

// ==== txq_fifo.sv ====
// Transmit queue FIFO with registered read data
`timescale 1ns/1ns
module txq_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8,
  localparam int unsigned AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int unsigned LW   = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // Drain side
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready,
  // Occupancy
  output logic      [LW-1:0]    o_level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [LW-1:0]    level_q;
  logic [LW-1:0]    mem_cnt;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             wr_fire;
  logic             rd_fire;
  logic             load;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign mem_cnt    = LW'(level_q - LW'(out_valid_q));
  assign o_wr_ready = (level_q != LW'(DEPTH));
  assign wr_fire    = i_wr_valid & o_wr_ready;
  assign rd_fire    = out_valid_q & i_rd_ready;
  assign load       = (mem_cnt != '0) & (~out_valid_q | i_rd_ready);
  assign o_rd_valid = out_valid_q;
  assign o_rd_data  = out_data_q;
  assign o_level    = level_q;

  always_ff @(posedge i_clock) begin
    if (wr_fire) begin
      mem[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (load) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (load) begin
      out_valid_q <= 1'b1;
      out_data_q  <= mem[rd_ptr_q];
    end else if (rd_fire) begin
      out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      level_q <= '0;
    end else if (wr_fire && !rd_fire) begin
      level_q <= LW'(level_q + 1'b1);
    end else if (rd_fire && !wr_fire) begin
      level_q <= LW'(level_q - 1'b1);
    end
  end

endmodule

// ==== uart_pkg.sv ====
// Shared constants for the transmit queue and interrupt identity slice
package uart_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned IDX_W         = 6;
  localparam logic [IDX_W-1:0] IDX_TXQ  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_ENA  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_IDN  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_LCR  = 6'h05;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ENA_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Enable register fields
  // ----------------------------------------------------------------
  localparam int unsigned EN_RDA        = 0;
  localparam int unsigned EN_TXE        = 1;
  localparam int unsigned EN_ERR        = 2;
  localparam int unsigned EN_MDM        = 3;
  localparam int unsigned EN_FLOW       = 4;
  localparam int unsigned EN_RTS        = 5;
  localparam int unsigned EN_CTS        = 6;

  // ----------------------------------------------------------------
  // Sticky source positions
  // ----------------------------------------------------------------
  localparam int unsigned NSTICKY       = 6;
  localparam int unsigned ST_ERR        = 0;
  localparam int unsigned ST_TXE        = 1;
  localparam int unsigned ST_MDM        = 2;
  localparam int unsigned ST_FLOW       = 3;
  localparam int unsigned ST_RTS        = 4;
  localparam int unsigned ST_CTS        = 5;

  // ----------------------------------------------------------------
  // Line condition register fields
  // ----------------------------------------------------------------
  localparam int unsigned LC_RX_READY   = 0;
  localparam int unsigned LC_TX_EMPTY   = 5;
  localparam int unsigned LC_TX_FULL    = 6;

  // ----------------------------------------------------------------
  // Transmit queue shape
  // ----------------------------------------------------------------
  localparam int unsigned TXQ_WIDTH     = 8;
  localparam int unsigned TXQ_DEPTH     = 8;

  // ----------------------------------------------------------------
  // Interrupt identity codes
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CODE_ERR  = 8'hc6,
    CODE_RDA  = 8'hc4,
    CODE_TMO  = 8'hcc,
    CODE_TXE  = 8'hc2,
    CODE_MDM  = 8'hc0,
    CODE_FLOW = 8'hd0,
    CODE_LINE = 8'he0,
    CODE_NONE = 8'hc1
  } irq_code_t;

endpackage

// ==== uart_tx_holding_irq.sv ====
// Transmit queue writes, interrupt enables and interrupt identity over Avalon-MM
// Summary of operation
// - Bytes written to the transmit queue register join the FIFO tail in order.
// - A write while the transmit FIFO is full is dropped, contents unchanged.
// - Enable bit 0 gates receive data ready and time-out reporting.
// - Enable bit 1 gates transmit queue empty reporting.
// - Enable bit 2 gates receive error reporting.
// - Enable bit 3 gates modem status change reporting.
// - Enable bit 4 gates flow control character detection reporting.
// - Enable bit 5 gates RTS or DTR change reporting.
// - Enable bit 6 gates CTS or DSR change; bit 7 reserved, resets zero.
// - Identity reads C1h when nothing enabled is pending, also after reset.
// - Identity shows the highest priority enabled source code, bit 0 cleared.
// - Line condition register shows transmit FIFO full and empty state.
`timescale 1ns/1ns
module uart_tx_holding_irq #(
  parameter int unsigned FIFO_DEPTH = uart_pkg::TXQ_DEPTH
) (
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_sys_rst,
  // Avalon-MM slave
  input  wire logic [uart_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [31:0]                 o_avs_readdata,
  output logic                             o_avs_waitrequest,
  // Receive path and modem events
  input  wire logic                        i_rx_data_ready,
  input  wire logic                        i_rx_timeout,
  input  wire logic                        i_rx_error,
  input  wire logic                        i_modem_change,
  input  wire logic                        i_flow_char,
  input  wire logic                        i_rts_dtr_change,
  input  wire logic                        i_cts_dsr_change,
  // Transmitter side of the queue
  output logic      [uart_pkg::TXQ_WIDTH-1:0] o_tx_data,
  output logic                             o_tx_valid,
  input  wire logic                        i_tx_ready,
  // Channel interrupt
  output logic                             o_irq
);

  import uart_pkg::*;

  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                wait_q;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic                req;
  logic                start;
  logic                done;
  logic                wr_lo;
  logic                txq_push;
  logic                txq_ready;
  logic                txq_pop;
  logic [LVL_W-1:0]    txq_level;
  logic                txq_full;
  logic                txq_empty;
  logic                empty_prev_q;
  logic [7:0]          ena_q;
  logic                ena_wr;
  logic                idn_rd;
  logic [NSTICKY-1:0]  sticky_q;
  logic [NSTICKY-1:0]  sticky_set;
  logic [NSTICKY-1:0]  sticky_clr;
  logic                en_err;
  logic                en_rda;
  logic                en_tmo;
  logic                en_txe;
  logic                en_mdm;
  logic                en_flow;
  logic                en_line;
  logic                any_en;
  irq_code_t           ident_d;
  logic                irq_q;

  // ----------------------------------------------------------------
  // Address decode and identity clear helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic [NSTICKY-1:0] clear_of(input logic [7:0] code);
    logic [NSTICKY-1:0] m;
    m = '0;
    if (code == CODE_ERR) begin
      m[ST_ERR] = 1'b1;
    end else if (code == CODE_TXE) begin
      m[ST_TXE] = 1'b1;
    end else if (code == CODE_MDM) begin
      m[ST_MDM] = 1'b1;
    end else if (code == CODE_FLOW) begin
      m[ST_FLOW] = 1'b1;
    end else if (code == CODE_LINE) begin
      m[ST_RTS] = 1'b1;
      m[ST_CTS] = 1'b1;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------------------------------
  assign req    = i_avs_read | i_avs_write;
  assign start  = req & wait_q;
  assign done   = req & ~wait_q;
  assign wr_lo  = done & i_avs_write & i_avs_byteenable[0];
  assign ena_wr = wr_lo & hit(i_avs_address, IDX_ENA);
  assign idn_rd = done & i_avs_read & hit(i_avs_address, IDX_IDN);

  // Drops for the answer cycle only, high again after it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~start;
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata    = rdata_q;

  // ----------------------------------------------------------------
  // Read data mux, captured in the first cycle of a read
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (hit(i_avs_address, IDX_ENA)) begin
      rdata_d[7:0] = ena_q;
    end else if (hit(i_avs_address, IDX_IDN)) begin
      rdata_d[7:0] = ident_d;
    end else if (hit(i_avs_address, IDX_LCR)) begin
      rdata_d[LC_RX_READY] = i_rx_data_ready;
      rdata_d[LC_TX_EMPTY] = txq_empty;
      rdata_d[LC_TX_FULL]  = txq_full;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_q <= RDATA_RESET;
    end else if (start && i_avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  assign txq_push  = wr_lo & hit(i_avs_address, IDX_TXQ);
  assign txq_pop   = o_tx_valid & i_tx_ready;
  assign txq_full  = ~txq_ready;
  assign txq_empty = (txq_level == '0);

  // Full queue drops the push inside the FIFO
  txq_fifo #(
    .WIDTH (TXQ_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_wr_valid (txq_push),
    .i_wr_data  (i_avs_writedata[TXQ_WIDTH-1:0]),
    .o_wr_ready (txq_ready),
    .o_rd_valid (o_tx_valid),
    .o_rd_data  (o_tx_data),
    .i_rd_ready (i_tx_ready),
    .o_level    (txq_level)
  );

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      empty_prev_q <= 1'b1;
    end else begin
      empty_prev_q <= txq_empty;
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ena_q <= ENA_RESET;
    end else if (ena_wr) begin
      ena_q <= i_avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky event sources; a new event beats a same-cycle clear
  // ----------------------------------------------------------------
  always_comb begin
    sticky_set          = '0;
    sticky_set[ST_ERR]  = i_rx_error;
    sticky_set[ST_TXE]  = (txq_empty & ~empty_prev_q) |
                          (ena_wr & i_avs_writedata[EN_TXE] & ~ena_q[EN_TXE] & txq_empty);
    sticky_set[ST_MDM]  = i_modem_change;
    sticky_set[ST_FLOW] = i_flow_char;
    sticky_set[ST_RTS]  = i_rts_dtr_change;
    sticky_set[ST_CTS]  = i_cts_dsr_change;
  end

  always_comb begin
    sticky_clr         = idn_rd ? clear_of(rdata_q[7:0]) : '0;
    sticky_clr[ST_TXE] = sticky_clr[ST_TXE] | txq_push;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= (sticky_q & ~sticky_clr) | sticky_set;
    end
  end

  // ----------------------------------------------------------------
  // Enable gating and priority encoding
  // ----------------------------------------------------------------
  assign en_rda  = i_rx_data_ready & ena_q[EN_RDA];
  assign en_tmo  = i_rx_timeout & ena_q[EN_RDA];
  assign en_txe  = sticky_q[ST_TXE] & ena_q[EN_TXE];
  assign en_err  = sticky_q[ST_ERR] & ena_q[EN_ERR];
  assign en_mdm  = sticky_q[ST_MDM] & ena_q[EN_MDM];
  assign en_flow = sticky_q[ST_FLOW] & ena_q[EN_FLOW];
  assign en_line = (sticky_q[ST_RTS] & ena_q[EN_RTS]) |
                   (sticky_q[ST_CTS] & ena_q[EN_CTS]);
  assign any_en  = en_err | en_rda | en_tmo | en_txe | en_mdm | en_flow | en_line;

  always_comb begin
    if (en_err) begin
      ident_d = CODE_ERR;
    end else if (en_rda) begin
      ident_d = CODE_RDA;
    end else if (en_tmo) begin
      ident_d = CODE_TMO;
    end else if (en_txe) begin
      ident_d = CODE_TXE;
    end else if (en_mdm) begin
      ident_d = CODE_MDM;
    end else if (en_flow) begin
      ident_d = CODE_FLOW;
    end else if (en_line) begin
      ident_d = CODE_LINE;
    end else begin
      ident_d = CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_en;
    end
  end

  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_push_appends: assert property (
    txq_push && !txq_full && !txq_pop |=> txq_level == LVL_W'($past(txq_level) + 1'b1))
    else $error("push did not grow the queue");

  a_full_drops: assert property (
    txq_push && txq_full && !txq_pop |=> txq_level == $past(txq_level))
    else $error("write to a full queue changed it");

  a_rda_gated: assert property (
    !ena_q[EN_RDA] |-> ident_d != CODE_RDA && ident_d != CODE_TMO)
    else $error("receive data reported while disabled");

  a_txe_gated: assert property (
    !ena_q[EN_TXE] |-> ident_d != CODE_TXE)
    else $error("queue empty reported while disabled");

  a_err_gated: assert property (
    !ena_q[EN_ERR] && $past(!ena_q[EN_ERR]) && i_rx_error |=> ident_d != CODE_ERR)
    else $error("receive error reported while disabled");

  a_mdm_gated: assert property (
    !ena_q[EN_MDM] |-> ident_d != CODE_MDM)
    else $error("modem change reported while disabled");

  a_flow_gated: assert property (
    !ena_q[EN_FLOW] |-> ident_d != CODE_FLOW)
    else $error("flow character reported while disabled");

  a_line_gated: assert property (
    !ena_q[EN_RTS] && !ena_q[EN_CTS] |-> ident_d != CODE_LINE)
    else $error("line change reported while disabled");

  a_idle_code: assert property (
    start && i_avs_read && hit(i_avs_address, IDX_IDN) && !any_en |=> o_avs_readdata == 32'h0000_00c1)
    else $error("idle identity is not C1h");

  a_err_wins: assert property (
    start && i_avs_read && hit(i_avs_address, IDX_IDN) && en_err |=> o_avs_readdata[7:0] == CODE_ERR)
    else $error("receive error did not take priority");

  a_full_shown: assert property (
    start && i_avs_read && hit(i_avs_address, IDX_LCR) |=> o_avs_readdata[LC_TX_FULL] == $past(txq_full))
    else $error("full flag not shown");

  a_empty_shown: assert property (
    start && i_avs_read && hit(i_avs_address, IDX_LCR) |=> o_avs_readdata[LC_TX_EMPTY] == $past(txq_empty))
    else $error("empty flag not shown");

  a_head_holds: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("queue head changed before it was taken");

  a_irq_tracks: assert property (
    any_en != $past(any_en) |=> o_irq == $past(any_en))
    else $error("interrupt output does not follow pending sources");

  a_one_wait: assert property (
    start |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus access not answered after one wait state");

  c_full_drop: cover property (txq_push && txq_full);
  c_err_read:  cover property (idn_rd && rdata_q[7:0] == CODE_ERR);
  c_line_clear: cover property (idn_rd && rdata_q[7:0] == CODE_LINE);
  c_irq_rise:  cover property ($rose(o_irq));
  c_drain:     cover property (txq_pop && txq_level == LVL_W'(1));

endmodule
